// file: swc_params.svh
// Constants for the SYSREF window capture block: offsets, field positions, resets.
// Assumes an 8-bit register port with a 12-bit address, as the device exposes it.
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH

`define SWC_ADDR_W 12
`define SWC_DATA_W 8
`define SWC_TAP_COUNT 24
`define SWC_PICK_W 4
`define SWC_LMFC_W 8

`define SWC_OFS_STATUS_LOW 12'h02C
`define SWC_OFS_STATUS_MID 12'h02D
`define SWC_OFS_STATUS_HIGH 12'h02E
`define SWC_OFS_DELAY_PICK 12'h029
`define SWC_OFS_STEP_FINE 12'h02A
`define SWC_OFS_LMFC_LEN 12'h031

`define SWC_POS_LOW_LSB 0
`define SWC_POS_MID_LSB 8
`define SWC_POS_HIGH_LSB 16
`define SWC_STEP_FINE_BIT 0

`define SWC_PICK_RESET 4'h0
`define SWC_FINE_RESET 1'b0
`define SWC_LMFC_LEN_RESET 8'h1F
`define SWC_STATUS_RESET 24'h80_0001

`endif

// file: swc_pkg.sv
// Types shared by the SYSREF window capture block.
// Assumes swc_params.svh is on the include path.
`include "swc_params.svh"

package swc_pkg;

  typedef struct packed {
    logic [`SWC_ADDR_W-1:0] addr;
    logic wrEn;
    logic rdEn;
    logic [`SWC_DATA_W-1:0] wrData;
  } swc_reg_req_t;

  typedef struct packed {
    logic rdValid;
    logic [`SWC_DATA_W-1:0] rdData;
  } swc_reg_rsp_t;

  typedef enum logic [0:0] {
    SWC_ARMED,
    SWC_HELD
  } swc_cap_state_t;

endpackage : swc_pkg

// file: swc_margin_detector.sv
// Margin detector: flags candidate delays whose SYSREF sample sits near a transition.
// Assumes tap samples arrive already aligned to sys_clk from the analog delay line.
`timescale 1ns/1ps
`include "swc_params.svh"

module swc_margin_detector (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`SWC_TAP_COUNT-1:0] tapSamples,
  output logic [`SWC_TAP_COUNT-1:0] marginStatus,
  output logic statusValid
);

  logic [`SWC_TAP_COUNT-1:0] prevTaps_r;
  logic [`SWC_TAP_COUNT-1:0] status_r;
  logic [`SWC_TAP_COUNT-1:0] status_nxt;
  logic [`SWC_TAP_COUNT-1:0] flags;
  logic valid_r;
  logic valid_nxt;
  logic edgeSeen;

  // The end taps have only one neighbour, so they are always reported as marginal.
  assign flags[0] = 1'b1;
  assign flags[`SWC_TAP_COUNT-1] = 1'b1;

  // An interior tap is marginal when either neighbour caught a different level.
  genvar gi;
  generate
    for (gi = 1; gi < `SWC_TAP_COUNT-1; gi = gi + 1) begin : gFlag
      assign flags[gi] = (tapSamples[gi] != tapSamples[gi-1]) ||
                         (tapSamples[gi] != tapSamples[gi+1]);
    end
  endgenerate

  assign edgeSeen = |(tapSamples & ~prevTaps_r);

  always_comb begin
    status_nxt = status_r;
    valid_nxt = valid_r;
    if (edgeSeen) begin
      status_nxt = flags;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prevTaps_r <= '0;
      status_r <= `SWC_STATUS_RESET;
      valid_r <= 1'b0;
    end else begin
      prevTaps_r <= tapSamples;
      status_r <= status_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign marginStatus = status_r;
  assign statusValid = valid_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_ENDS_FLAGGED: assert property (statusValid |-> marginStatus[0] && marginStatus[23])
    else $error("End taps of the margin status are not set.");
  AST_STATUS_HOLDS: assert property (!edgeSeen |=> $stable(status_r))
    else $error("Margin status changed without a SYSREF edge.");
  AST_FLAG_TRANSITION: assert property (edgeSeen && (tapSamples[5] != tapSamples[4])
    |=> status_r[5] && status_r[4])
    else $error("A transition between taps 4 and 5 was not flagged on both.");
  AST_CLEAN_TAP: assert property (edgeSeen && (tapSamples[11:9] == 3'b111)
    |=> !status_r[10])
    else $error("A tap with settled neighbours was flagged marginal.");
  COV_STATUS_FILL: cover property (edgeSeen ##1 statusValid);

endmodule : swc_margin_detector

// file: swc_sysref_window_capture.sv
// SYSREF window capture: delayed-tap selection, margin status registers, framing reset.
// Assumes the analog delay line presents one SYSREF sample per candidate delay each
// device clock cycle, and that its step spacing follows delayStepFine.
`timescale 1ns/1ps
`include "swc_params.svh"

module swc_sysref_window_capture (
  input wire logic sys_clk,
  input wire logic reset,
  input wire swc_pkg::swc_reg_req_t regReq,
  output swc_pkg::swc_reg_rsp_t regRsp,
  input wire logic [`SWC_TAP_COUNT-1:0] tapSamples,
  output logic delayStepFine,
  output logic sysrefEvent,
  output logic lmfcBoundary
);

  // Register file state.
  logic [`SWC_PICK_W-1:0] delayPick_r;
  logic [`SWC_PICK_W-1:0] delayPick_nxt;
  logic stepFine_r;
  logic stepFine_nxt;
  logic [`SWC_LMFC_W-1:0] lmfcLen_r;
  logic [`SWC_LMFC_W-1:0] lmfcLen_nxt;
  swc_pkg::swc_reg_rsp_t rsp_r;
  swc_pkg::swc_reg_rsp_t rsp_nxt;

  // Capture state.
  swc_pkg::swc_cap_state_t capState_r;
  swc_pkg::swc_cap_state_t capState_nxt;
  logic [`SWC_PICK_W-1:0] activePick_r;
  logic [`SWC_PICK_W-1:0] activePick_nxt;
  logic event_r;
  logic event_nxt;
  logic pickedSample;

  // Framing counter state.
  logic [`SWC_LMFC_W-1:0] lmfcCount_r;
  logic [`SWC_LMFC_W-1:0] lmfcCount_nxt;
  logic boundary_r;
  logic boundary_nxt;

  logic [`SWC_TAP_COUNT-1:0] marginStatus;
  logic statusValid;

  swc_margin_detector uDetector (
    .sys_clk(sys_clk),
    .reset(reset),
    .tapSamples(tapSamples),
    .marginStatus(marginStatus),
    .statusValid(statusValid)
  );

  // Register writes. The status offsets are not decoded for writes at all.
  always_comb begin
    delayPick_nxt = delayPick_r;
    stepFine_nxt = stepFine_r;
    lmfcLen_nxt = lmfcLen_r;
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        `SWC_OFS_DELAY_PICK: begin
          // Only the low four bits exist, so taps 16 to 23 cannot be chosen.
          delayPick_nxt = regReq.wrData[`SWC_PICK_W-1:0];
        end
        `SWC_OFS_STEP_FINE: begin
          stepFine_nxt = regReq.wrData[`SWC_STEP_FINE_BIT];
        end
        `SWC_OFS_LMFC_LEN: begin
          lmfcLen_nxt = regReq.wrData;
        end
        default: begin
          delayPick_nxt = delayPick_r;
        end
      endcase
    end
  end

  // Register reads answer one cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    rsp_nxt.rdValid = regReq.rdEn;
    rsp_nxt.rdData = '0;
    if (regReq.rdEn) begin
      unique case (regReq.addr)
        `SWC_OFS_STATUS_LOW: begin
          rsp_nxt.rdData = marginStatus[`SWC_POS_LOW_LSB +: `SWC_DATA_W];
        end
        `SWC_OFS_STATUS_MID: begin
          rsp_nxt.rdData = marginStatus[`SWC_POS_MID_LSB +: `SWC_DATA_W];
        end
        `SWC_OFS_STATUS_HIGH: begin
          rsp_nxt.rdData = marginStatus[`SWC_POS_HIGH_LSB +: `SWC_DATA_W];
        end
        `SWC_OFS_DELAY_PICK: begin
          rsp_nxt.rdData = {4'h0, delayPick_r};
        end
        `SWC_OFS_STEP_FINE: begin
          rsp_nxt.rdData = {7'h00, stepFine_r};
        end
        `SWC_OFS_LMFC_LEN: begin
          rsp_nxt.rdData = lmfcLen_r;
        end
        default: begin
          rsp_nxt.rdData = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      delayPick_r <= `SWC_PICK_RESET;
      stepFine_r <= `SWC_FINE_RESET;
      lmfcLen_r <= `SWC_LMFC_LEN_RESET;
      rsp_r <= '0;
    end else begin
      delayPick_r <= delayPick_nxt;
      stepFine_r <= stepFine_nxt;
      lmfcLen_r <= lmfcLen_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // The selected tap is the SYSREF sample taken by the chosen delayed clock copy.
  assign pickedSample = tapSamples[activePick_r];

  // Capture: armed while the picked sample is low, where a new pick is adopted, so
  // a change never splits a pulse. A rising edge gives one event on the next clock edge,
  // whether SYSREF is a lone pulse or a periodic train.
  always_comb begin
    capState_nxt = capState_r;
    activePick_nxt = activePick_r;
    event_nxt = 1'b0;
    unique case (capState_r)
      swc_pkg::SWC_ARMED: begin
        if (pickedSample) begin
          event_nxt = 1'b1;
          capState_nxt = swc_pkg::SWC_HELD;
        end else begin
          activePick_nxt = delayPick_r;
        end
      end
      swc_pkg::SWC_HELD: begin
        if (!pickedSample) begin
          capState_nxt = swc_pkg::SWC_ARMED;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      capState_r <= swc_pkg::SWC_HELD;
      activePick_r <= `SWC_PICK_RESET;
      event_r <= 1'b0;
    end else begin
      capState_r <= capState_nxt;
      activePick_r <= activePick_nxt;
      event_r <= event_nxt;
    end
  end

  // Multiframe counter: wraps at the programmed length and restarts on each event,
  // so a periodic SYSREF at a submultiple of the frame rate lands on a boundary.
  always_comb begin
    lmfcCount_nxt = lmfcCount_r + 8'h01;
    boundary_nxt = 1'b0;
    if (event_nxt) begin
      lmfcCount_nxt = '0;
      boundary_nxt = 1'b1;
    end else if (lmfcCount_r == lmfcLen_r) begin
      lmfcCount_nxt = '0;
      boundary_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lmfcCount_r <= '0;
      boundary_r <= 1'b0;
    end else begin
      lmfcCount_r <= lmfcCount_nxt;
      boundary_r <= boundary_nxt;
    end
  end

  assign regRsp = rsp_r;
  assign delayStepFine = stepFine_r;
  assign sysrefEvent = event_r;
  assign lmfcBoundary = boundary_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_PICK_WRITE: assert property (regReq.wrEn && regReq.addr == `SWC_OFS_DELAY_PICK
    |=> delayPick_r == $past(regReq.wrData[3:0]))
    else $error("Delay pick register did not take the written index.");
  AST_FINE_WRITE: assert property (regReq.wrEn && regReq.addr == `SWC_OFS_STEP_FINE
    |=> delayStepFine == $past(regReq.wrData[0]))
    else $error("Step granularity output did not follow the write.");
  AST_RESET_ZERO: assert property (disable iff (1'b0) $fell(reset)
    |-> delayPick_r == 4'h0 && !delayStepFine)
    else $error("Pick or granularity not zero after reset.");
  AST_EVENT_CAUSE: assert property (sysrefEvent |-> $past(capState_r == swc_pkg::SWC_ARMED)
    && $past(pickedSample))
    else $error("Event raised without an armed rising sample.");
  AST_EVENT_ONCE: assert property (sysrefEvent |=> !sysrefEvent)
    else $error("One SYSREF pulse produced two events.");
  AST_LMFC_RESTART: assert property (sysrefEvent |-> lmfcCount_r == 8'h00 && lmfcBoundary
    ##1 lmfcCount_r == 8'h01)
    else $error("Framing counter not restarted by the SYSREF event.");
  AST_PICK_HELD: assert property (capState_r == swc_pkg::SWC_HELD |=> $stable(activePick_r))
    else $error("Active pick changed while a pulse was high.");
  AST_STATUS_READ: assert property (regReq.rdEn && regReq.addr == `SWC_OFS_STATUS_HIGH
    |=> regRsp.rdValid && regRsp.rdData == $past(marginStatus[23:16]))
    else $error("High status byte read back wrong.");
  AST_STATUS_RO: assert property (regReq.wrEn && regReq.addr == `SWC_OFS_STATUS_LOW
    && !regReq.rdEn |=> regRsp.rdData == 8'h00)
    else $error("Write to a status byte produced read data.");

  AST_READ_ONE_CYCLE: assert property (regReq.rdEn |=> regRsp.rdValid)
    else $error("Read strobe was not answered in the next cycle.");

  // Read data must stay zero between answers so stale status never leaks out.
  AST_READ_QUIET: assert property (!regRsp.rdValid |-> regRsp.rdData == 8'h00)
    else $error("Read data not zero while no answer is valid.");

  AST_STATUS_LOW_READ: assert property (regReq.rdEn && regReq.addr == `SWC_OFS_STATUS_LOW
    |=> regRsp.rdData == $past(marginStatus[7:0]))
    else $error("Low status byte read back wrong.");

  AST_STATUS_MID_READ: assert property (regReq.rdEn && regReq.addr == `SWC_OFS_STATUS_MID
    |=> regRsp.rdData == $past(marginStatus[15:8]))
    else $error("Middle status byte read back wrong.");

  AST_PICK_READ: assert property (regReq.rdEn && regReq.addr == `SWC_OFS_DELAY_PICK
    |=> regRsp.rdData == {4'h0, $past(delayPick_r)})
    else $error("Delay pick register read back wrong.");

  AST_PICK_STABLE: assert property (!(regReq.wrEn && regReq.addr == `SWC_OFS_DELAY_PICK)
    |=> $stable(delayPick_r))
    else $error("Delay pick changed without a write.");

  AST_FINE_STABLE: assert property (!(regReq.wrEn && regReq.addr == `SWC_OFS_STEP_FINE)
    |=> $stable(delayStepFine))
    else $error("Step granularity changed without a write.");

  // A new pick is only taken while the picked tap is low, never in mid pulse.
  AST_PICK_ADOPT: assert property (capState_r == swc_pkg::SWC_ARMED && !pickedSample
    |=> activePick_r == $past(delayPick_r))
    else $error("Active pick did not follow the programmed pick while armed.");

  AST_NO_EVENT_HELD: assert property (capState_r == swc_pkg::SWC_HELD |=> !sysrefEvent)
    else $error("Event raised before the picked tap returned low.");

  AST_LMFC_WRAP: assert property (!event_nxt && lmfcCount_r == lmfcLen_r
    |=> lmfcBoundary && lmfcCount_r == 8'h00)
    else $error("Framing counter did not wrap at the programmed length.");

  COV_PULSE: cover property (!pickedSample ##1 pickedSample ##1 sysrefEvent);
  COV_WRAP: cover property (lmfcBoundary && !sysrefEvent);
  COV_PERIODIC: cover property (sysrefEvent ##[2:300] sysrefEvent);
  COV_FINE_PICK: cover property (delayStepFine && activePick_r == 4'hF && sysrefEvent);

endmodule : swc_sysref_window_capture

// file: swc_sysref_source.sv
// Model of the external SYSREF source as the delayed taps see it.
// Assumes one-cycle pulses whose edge falls between taps skew-1 and skew.
`timescale 1ns/1ps

module swc_sysref_source (
  input wire logic sys_clk,
  input wire logic fireReq,
  input wire logic [4:0] skew,
  output logic [23:0] tapSamples
);
  logic pend = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [23:0] lateMask;

  assign lateMask = 24'hFF_FFFF << skew;
  initial tapSamples = 24'h00_0000;

  // Requests are taken on the rising edge so the bench may change them off that edge.
  always @(posedge sys_clk) begin
    pend <= fireReq;
  end

  // Late taps catch the pulse one cycle before the early taps; the line idles low.
  always @(negedge sys_clk) begin
    case (phase)
      2'h0: if (pend) begin
        tapSamples <= lateMask;
        phase <= 2'h1;
      end
      2'h1: begin
        tapSamples <= ~lateMask;
        phase <= 2'h2;
      end
      default: begin
        tapSamples <= 24'h00_0000;
        phase <= 2'h0;
      end
    endcase
  end
endmodule : swc_sysref_source

// file: tb_top.sv
// Self-checking bench for the SYSREF window capture block.
// Assumes swc_params.svh on the include path and the source model alongside.
`timescale 1ns/1ps
`include "swc_params.svh"

module tb_top;
  logic sys_clk;
  logic reset;
  swc_pkg::swc_reg_req_t regReq;
  swc_pkg::swc_reg_rsp_t regRsp;
  logic [23:0] tapSamples;
  logic delayStepFine;
  logic sysrefEvent;
  logic lmfcBoundary;
  logic fireReq;
  logic [4:0] skew;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 32'h22c0_f68d;
  logic [7:0] rdQ[$];
  int evQ[$];

  swc_sysref_window_capture u_dut (.sys_clk(sys_clk), .reset(reset), .regReq(regReq),
    .regRsp(regRsp), .tapSamples(tapSamples), .delayStepFine(delayStepFine),
    .sysrefEvent(sysrefEvent), .lmfcBoundary(lmfcBoundary));
  swc_sysref_source u_src (.sys_clk(sys_clk), .fireReq(fireReq), .skew(skew),
    .tapSamples(tapSamples));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic wr, input logic [11:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    regReq.addr = addr;
    regReq.wrEn = wr;
    regReq.rdEn = ~wr;
    regReq.wrData = data;
  endtask : bus

  task automatic rd(input logic [11:0] addr, input logic [7:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, addr, 8'h00);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      regReq = '0;
      fireReq = 1'b0;
    end
  endtask : idle

  task automatic rdStatus(input logic [23:0] exp);
    rd(`SWC_OFS_STATUS_LOW, exp[7:0]);
    rd(`SWC_OFS_STATUS_MID, exp[15:8]);
    rd(`SWC_OFS_STATUS_HIGH, exp[23:16]);
    idle(1);
  endtask : rdStatus

  // The picked tap rises one cycle later when it lies below the edge.
  task automatic pulse(input logic [4:0] p, input logic [4:0] s);
    @(negedge sys_clk);
    skew = s;
    fireReq = 1'b1;
    evQ.push_back(cyc + ((p >= s) ? 2 : 3));
    idle(1);
  endtask : pulse

  always @(negedge sys_clk) begin
    if (!reset && regRsp.rdValid === 1'b1) begin
      if (rdQ.size() == 0) chk("readValid", 24'h0, 24'h1);
      else chk("readData", 24'(rdQ.pop_front()), 24'(regRsp.rdData));
    end
    if (!reset && sysrefEvent === 1'b1) begin
      if (evQ.size() == 0) chk("sysrefEvent", 24'h0, 24'h1);
      else chk("eventCycle", 24'(evQ.pop_front()), 24'(cyc));
      chk("lmfcBoundary", 24'h1, 24'(lmfcBoundary));
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    chk("timeout", 24'h0, 24'h1);
    wrap_up();
  end

  initial begin
    logic [4:0] p;
    logic [4:0] s;
    logic [23:0] exp;
    reset = 1'b1;
    regReq = '0;
    fireReq = 1'b0;
    skew = 5'h00;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    chk("fineAtReset", 24'h0, 24'(delayStepFine));
    rd(`SWC_OFS_DELAY_PICK, 8'h00);
    rd(`SWC_OFS_STEP_FINE, 8'h00);
    rdStatus(24'h80_0001);
    rd(`SWC_OFS_LMFC_LEN, 8'h1F);
    bus(1'b1, `SWC_OFS_LMFC_LEN, 8'h3C);
    rd(`SWC_OFS_LMFC_LEN, 8'h3C);
    bus(1'b1, `SWC_OFS_STEP_FINE, 8'h01);
    idle(1);
    chk("fine", 24'h1, 24'(delayStepFine));
    rd(`SWC_OFS_STEP_FINE, 8'h01);
    bus(1'b1, `SWC_OFS_STEP_FINE, 8'h00);
    idle(1);
    chk("coarse", 24'h0, 24'(delayStepFine));
    bus(1'b1, `SWC_OFS_DELAY_PICK, 8'h1F);
    rd(`SWC_OFS_DELAY_PICK, 8'h0F);
    rd(12'h123, 8'h00);
    idle(1);
    for (int k = 0; k < 6; k++) begin
      p = 5'($unsigned($random(seed)) % 16);
      s = 5'(2 + $unsigned($random(seed)) % 21);
      bus(1'b1, `SWC_OFS_DELAY_PICK, {3'h0, p});
      idle(3);
      pulse(p, s);
      idle(6);
      exp = 24'h80_0001 | (24'h3 << (s - 5'h1));
      rdStatus(exp);
    end
    bus(1'b1, `SWC_OFS_STATUS_LOW, 8'hFE);
    bus(1'b1, `SWC_OFS_STATUS_HIGH, 8'h00);
    idle(1);
    rdStatus(exp);
    bus(1'b1, `SWC_OFS_DELAY_PICK, 8'h04);
    idle(3);
    // Periodic SYSREF every 8 cycles.
    repeat (3) begin
      pulse(5'h04, 5'h08);
      idle(6);
    end
    idle(10);
    // Mid-run reset: the stored pick is written again rather than re-measured.
    @(negedge sys_clk);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    rd(`SWC_OFS_DELAY_PICK, 8'h00);
    rd(`SWC_OFS_LMFC_LEN, 8'h1F);
    rdStatus(24'h80_0001);
    bus(1'b1, `SWC_OFS_DELAY_PICK, 8'h04);
    idle(3);
    pulse(5'h04, 5'h03);
    idle(6);
    rdStatus(24'h80_000D);
    idle(4);
    chk("pending", 24'h0, 24'(rdQ.size() + evQ.size()));
    wrap_up();
  end
endmodule : tb_top
